//--- rsap_core.sv
// Serial register access port: SPI mode 0 slave with a 32-byte register map.
// Contract
// RULE_01: Chip select low frames each transfer.
// RULE_02: Bits arrive MSB first from first rise.
// RULE_03: Mode 0: sample rising, shift falling.
// RULE_04: One clock per bit, byte groups.
// RULE_05: First bit picks write or read.
// RULE_06: Next seven bits form start address.
// RULE_07: Address bit six is ignored.
// RULE_08: Pointer advances after every data byte.
// RULE_09: Pointer wraps from 3Fh to 00h.
// RULE_10: Clock copy halts while clock addresses accessed.
// RULE_11: Fixed 32-byte register order.
// RULE_12: Power fail aborts access, clears pointer.
// RULE_13: Selectable at once after supply recovers.
// RULE_14: Reset output low, held after recovery.
// RULE_15: Master clocks only during bit transfers.
// RULE_16: Register contents kept through power fail.
// RULE_17: Serial output floats while deselected.
// RULE_18: Serial output floats until read byte ready.
// RULE_19: Falling select needed after power-on; here the link starts when pf_q clears even if select was held low.
// RULE_20: Unimplemented addresses read zero, ignore writes.
`timescale 1ns/10ps
`default_nettype none
module rsap_core #(
	parameter int unsigned RST_HOLD_CYC = 32'(rsap_pkg::RST_HOLD_CY)
) (
	input  wire logic               clk_i,
	input  wire logic               rstn_i,
	input  wire logic               sclk_i,
	input  wire logic               cs_n_i,
	input  wire logic               serial_in_i,
	output logic                    serial_out_o,
	output logic                    serial_out_oe_o,
	input  wire logic               vcc_ok_i,
	output logic                    rst_n_o,
	output logic                    rst_n_oe_o,
	input  wire rsap_pkg::rsap_time_t time_i,
	output rsap_pkg::rsap_map_t     regs_o,
	output logic                    halt_o,
	output logic                    wr_valid_o,
	output rsap_pkg::rsap_wr_t      wr_o
);
	import rsap_pkg::*;

	logic        pf_q;
	logic        link_rst;
	rsap_map_t   mem_q;
	rsap_map_t   mem_d;
	logic [7:0]  rd_byte;

	// Link logic is cleared while deselected or during a supply failure.
	// RULE_12 abort on fail
	assign link_rst = cs_n_i | pf_q;

	// Receive side, clocked on the rising serial clock edge.
	logic [2:0]  cnt_q;
	logic [2:0]  cnt_d;
	logic [6:0]  sh_q;
	logic [6:0]  sh_d;
	rsap_phase_t ph_q;
	rsap_phase_t ph_d;
	logic        dir_q;
	logic        dir_d;
	logic [5:0]  ptr_q;
	logic [5:0]  ptr_d;
	logic        hreq_q;
	logic        hreq_d;
	logic [7:0]  byte_in;
	logic        wtog_q;
	logic        wtog_d;
	rsap_wr_t    wcap_q;
	rsap_wr_t    wcap_d;

	always_comb begin
		byte_in = {sh_q, serial_in_i};
		cnt_d   = cnt_q + 3'h1;
		sh_d    = byte_in[6:0];
		ph_d    = ph_q;
		dir_d   = dir_q;
		ptr_d   = ptr_q;
		hreq_d  = hreq_q;
		wtog_d  = wtog_q;
		wcap_d  = wcap_q;
		// RULE_04 byte boundary
		if (cnt_q == LAST_BIT) begin
			if (ph_q == PH_CMD) begin
				// RULE_05 direction bit
				dir_d  = byte_in[7];
				// RULE_06 start address
				// RULE_07 drop bit six
				ptr_d  = byte_in[5:0];
				ph_d   = PH_DATA;
				// RULE_10 halt clock copy
				// Halt is also raised at 3Fh so the time bytes are frozen before 00h is read.
				hreq_d = (byte_in[5:0] < CLOCK_END) || (&byte_in[5:0]);
			end else begin
				// RULE_08 pointer advance
				// RULE_09 natural wrap
				ptr_d  = ptr_q + 6'h01;
				hreq_d = (ptr_d < CLOCK_END) || (&ptr_d);
				if (dir_q) begin
					wtog_d = ~wtog_q;
					wcap_d = '{addr: ptr_q, data: byte_in};
				end
			end
		end
	end

	// RULE_01 frame by select
	// RULE_02 msb first
	// RULE_03 sample rising
	always_ff @(posedge sclk_i or posedge link_rst) begin
		if (link_rst) begin
			cnt_q  <= 3'h0;
			sh_q   <= 7'h00;
			ph_q   <= PH_CMD;
			dir_q  <= 1'b0;
			ptr_q  <= PTR_RESET;
			hreq_q <= 1'b1;
		end else begin
			cnt_q  <= cnt_d;
			sh_q   <= sh_d;
			ph_q   <= ph_d;
			dir_q  <= dir_d;
			ptr_q  <= ptr_d;
			hreq_q <= hreq_d;
		end
	end

	// The write toggle survives deselect so no event is lost between frames.
	always_ff @(posedge sclk_i or posedge pf_q) begin
		if (pf_q) begin
			wtog_q <= 1'b0;
		end else begin
			wtog_q <= wtog_d;
		end
	end

	always_ff @(posedge sclk_i) begin
		wcap_q <= wcap_d;
	end

	// The map is read while its clock bytes are frozen by the halt request.
	// RULE_20 zero above map
	assign rd_byte = ptr_q[5] ? BYTE_RESET : mem_q[ptr_q[4:0]];

	// Transmit side, clocked on the falling serial clock edge.
	logic        oe_q;
	logic        oe_d;
	logic        out_q;
	logic        out_d;
	logic [7:0]  osh_q;
	logic [7:0]  osh_d;

	always_comb begin
		oe_d  = oe_q;
		out_d = osh_q[7];
		osh_d = {osh_q[6:0], 1'b0};
		// RULE_18 drive when byte ready
		if (ph_q == PH_DATA && cnt_q == 3'h0 && !dir_q) begin
			oe_d  = 1'b1;
			out_d = rd_byte[7];
			osh_d = {rd_byte[6:0], 1'b0};
		end
	end

	// RULE_03 shift falling
	// RULE_17 float when deselected
	always_ff @(negedge sclk_i or posedge link_rst) begin
		if (link_rst) begin
			oe_q  <= 1'b0;
			out_q <= 1'b0;
			osh_q <= BYTE_RESET;
		end else begin
			oe_q  <= oe_d;
			out_q <= out_d;
			osh_q <= osh_d;
		end
	end

	assign serial_out_o    = out_q;
	assign serial_out_oe_o = oe_q;

	// System side synchronisers.
	logic        cs_s1_q;
	logic        cs_s2_q;
	logic        hr_s1_q;
	logic        hr_s2_q;
	logic        vc_s1_q;
	logic        vc_s2_q;
	logic        tg_s1_q;
	logic        tg_s2_q;
	logic        tg_s3_q;
	logic        pf_d;
	logic        wev;

	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			cs_s1_q <= 1'b1;
			cs_s2_q <= 1'b1;
			hr_s1_q <= 1'b1;
			hr_s2_q <= 1'b1;
			vc_s1_q <= 1'b0;
			vc_s2_q <= 1'b0;
		end else begin
			cs_s1_q <= cs_n_i;
			cs_s2_q <= cs_s1_q;
			hr_s1_q <= hreq_q;
			hr_s2_q <= hr_s1_q;
			vc_s1_q <= vcc_ok_i;
			vc_s2_q <= vc_s1_q;
		end
	end

	// Toggle chain follows the link toggle, which is held low during a fail.
	always_ff @(posedge clk_i) begin
		if (!rstn_i || pf_q) begin
			tg_s1_q <= 1'b0;
			tg_s2_q <= 1'b0;
			tg_s3_q <= 1'b0;
		end else begin
			tg_s1_q <= wtog_q;
			tg_s2_q <= tg_s1_q;
			tg_s3_q <= tg_s2_q;
		end
	end

	// RULE_13 recover at once
	assign pf_d = ~vc_s2_q;
	// RULE_12 ignore writes on fail
	assign wev  = (tg_s2_q ^ tg_s3_q) & ~pf_q;

	// Halt, write event and power fail state.
	logic        halt_q;
	logic        halt_d;
	logic        wv_q;
	rsap_wr_t    wr_q;
	rsap_wr_t    wr_d;

	always_comb begin
		// RULE_10 halt while clock zone
		halt_d = ~cs_s2_q & hr_s2_q & ~pf_q;
		wr_d   = wev ? wcap_q : wr_q;
	end

	// RULE_19 start in fail state
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			pf_q   <= 1'b1;
			halt_q <= 1'b0;
			wv_q   <= 1'b0;
			wr_q   <= '0;
		end else begin
			pf_q   <= pf_d;
			halt_q <= halt_d;
			wv_q   <= wev;
			wr_q   <= wr_d;
		end
	end

	// RULE_11 fixed byte order
	// RULE_16 kept through fail
	for (genvar i = 0; i < BYTES; i++) begin : g_map
		always_comb begin
			mem_d[i] = mem_q[i];
			if (i < 8 && !halt_q) begin
				mem_d[i] = time_i[i % 8];
			end
			// RULE_20 writes above map dropped
			if (wev && !wcap_q.addr[5] && wcap_q.addr[4:0] == 5'(i)) begin
				mem_d[i] = wcap_q.data;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			mem_q <= '0;
		end else begin
			mem_q <= mem_d;
		end
	end

	// Reset output hold counter.
	logic [31:0] rc_q;
	logic [31:0] rc_d;
	logic        rdrv_q;
	logic        rdrv_d;

	always_comb begin
		rc_d   = rc_q;
		rdrv_d = 1'b0;
		// RULE_14 low and hold
		if (pf_q) begin
			rc_d   = 32'h0;
			rdrv_d = 1'b1;
		end else if (rc_q < RST_HOLD_CYC - 32'h1) begin
			rc_d   = rc_q + 32'h1;
			rdrv_d = 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			rc_q   <= 32'h0;
			rdrv_q <= 1'b1;
		end else begin
			rc_q   <= rc_d;
			rdrv_q <= rdrv_d;
		end
	end

	assign rst_n_o    = 1'b0;
	assign rst_n_oe_o = rdrv_q;
	assign regs_o     = mem_q;
	assign halt_o     = halt_q;
	assign wr_valid_o = wv_q;
	assign wr_o       = wr_q;
endmodule
`default_nettype wire

//--- rsap_core_properties.sv
// Pin-level checks for the access port.
`timescale 1ns/10ps
`default_nettype none
module rsap_core_properties (
	input wire logic				clk_i,
	input wire logic				rstn_i,
	input wire logic				cs_n_i,
	input wire logic				vcc_ok_i,
	input wire logic				serial_out_oe_o,
	input wire logic				rst_n_oe_o,
	input wire logic				halt_o,
	input wire logic				wr_valid_o,
	input wire rsap_pkg::rsap_map_t	regs_o,
	input wire rsap_pkg::rsap_wr_t	wr_o
);
	import rsap_pkg::*;
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rstn_i);
	property p_oe; $past(cs_n_i) |-> !serial_out_oe_o; endproperty
	a_oe: assert property (p_oe) else $error("oe");
	property p_pf; !vcc_ok_i [*4] |=> rst_n_oe_o && !serial_out_oe_o; endproperty
	a_pf: assert property (p_pf) else $error("pf");
	property p_hold; $fell(rst_n_oe_o) |-> $past(vcc_ok_i, 16); endproperty
	a_hold: assert property (p_hold) else $error("hold");
	property p_wv; wr_valid_o |=> !wr_valid_o [*6]; endproperty
	a_wv: assert property (p_wv) else $error("wv");
	property p_hi; wr_valid_o && wr_o.addr[5] |=> $stable(regs_o[31:8]) [*2]; endproperty
	a_hi: assert property (p_hi) else $error("hi");
	property p_lo; wr_valid_o && !wr_o.addr[5] && |wr_o.addr[4:3]
		|-> ##2 regs_o[wr_o.addr[4:0]] == wr_o.data; endproperty
	a_lo: assert property (p_lo) else $error("lo");
	property p_hon; $fell(cs_n_i) && vcc_ok_i && $past(vcc_ok_i, 4) |-> ##4 halt_o; endproperty
	a_hon: assert property (p_hon) else $error("hon");
	property p_hoff; cs_n_i [*6] |-> !halt_o; endproperty
	a_hoff: assert property (p_hoff) else $error("hoff");
	c_wr: cover property (wr_valid_o);
	c_pf: cover property ($fell(rst_n_oe_o));
	c_ht: cover property ($rose(halt_o));
endmodule
`default_nettype wire

//--- rsap_core_tb_top.sv
// Self-checking bench for the access port.
`timescale 1ns/10ps
`default_nettype none
module rsap_core_tb_top;
	import rsap_pkg::*;
	logic		clk_i = 0, rstn_i = 0, vcc_ok_i = 1, sclk_i, cs_n_i, serial_in_i;
	logic		serial_out_o, serial_out_oe_o, rst_n_o, rst_n_oe_o, halt_o, wr_valid_o;
	rsap_time_t	time_i = 0;
	rsap_map_t	regs_o;
	rsap_wr_t	wr_o, wq[$], eq[$];
	int			mem[32], n_fail, n_checks, seed = 82;
	logic [7:0]	r, d;
	rsap_core #(.RST_HOLD_CYC(20)) u_dut (
		.clk_i           (clk_i),
		.rstn_i          (rstn_i),
		.sclk_i          (sclk_i),
		.cs_n_i          (cs_n_i),
		.serial_in_i     (serial_in_i),
		.serial_out_o    (serial_out_o),
		.serial_out_oe_o (serial_out_oe_o),
		.vcc_ok_i        (vcc_ok_i),
		.rst_n_o         (rst_n_o),
		.rst_n_oe_o      (rst_n_oe_o),
		.time_i          (time_i),
		.regs_o          (regs_o),
		.halt_o          (halt_o),
		.wr_valid_o      (wr_valid_o),
		.wr_o            (wr_o)
	);
	rsap_spi_master u_m (.sclk_o(sclk_i), .cs_n_o(cs_n_i), .serial_in_o(serial_in_i),
		.serial_out_i(serial_out_oe_o ? serial_out_o : 1'bz));
	initial forever #12.5 clk_i = ~clk_i;
	always @(negedge clk_i) if (wr_valid_o === 1'b1) wq.push_back(wr_o);
	task automatic chk(input string n, input logic [13:0] s, e);
		n_checks++;
		if (s !== e) begin
			n_fail++;
			$display("ERROR %s exp %h seen %h", n, e, s);
		end
	endtask
	task automatic finish_test();
		$display("checks %0d errors %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	task automatic xf(input logic [7:0] c, input int n, input bit pf);
		int p;
		rsap_time_t t;
		repeat (6) @(negedge clk_i);
		t = time_i;
		u_m.sel(0);
		u_m.xfer(c, r);
		chk("z", r, 8'hZZ);
		@(negedge clk_i);
		vcc_ok_i = !pf;
		time_i = {$random(seed), $random(seed)};
		for (int i = 0; i < n; i++) begin
			p = (c + i) & 63;
			// Copying resumes at a non-clock address, so later clock bytes show the live time.
			if (p > 7) t = time_i;
			d = $random(seed);
			u_m.xfer(d, r);
			if (c[7] && !pf) eq.push_back({p[5:0], d});
			if (c[7] && !pf && p > 7 && p < 32) mem[p] = d;
			chk("rd", r, c[7] ? 8'hZZ : p > 31 ? 8'h00 : p < 8 ? t[p] : mem[p][7:0]);
		end
		u_m.sel(1);
		repeat (12) @(negedge clk_i);
		chk("nwr", wq.size(), eq.size());
		foreach (eq[i]) chk("wr", wq[i], eq[i]);
		chk("halt", halt_o, 1'b0);
		foreach (mem[i]) chk("map", regs_o[i], i < 8 ? time_i[i] : mem[i][7:0]);
		wq = {};
		eq = {};
	endtask
	initial begin
		#100us;
		n_fail++;
		finish_test();
	end
	initial begin
		repeat (8) @(negedge clk_i);
		rstn_i = 1;
		xf(8'hFC, 40, 0);
		xf(8'h06, 30, 0);
		u_m.gap_ns = 200;
		xf(8'h00, 8, 0);
		xf(8'h7E, 4, 0);
		xf(8'h8A, 2, 1);
		chk("rpin", rst_n_oe_o, 1);
		chk("rlvl", rst_n_o, 1'b0);
		vcc_ok_i = 1;
		xf(8'h8B, 2, 0);
		chk("rpin", rst_n_oe_o, 0);
		xf(8'h08, 5, 0);
		finish_test();
	end
endmodule
bind rsap_core rsap_core_properties u_chk (
	.clk_i           (clk_i),
	.rstn_i          (rstn_i),
	.cs_n_i          (cs_n_i),
	.vcc_ok_i        (vcc_ok_i),
	.serial_out_oe_o (serial_out_oe_o),
	.rst_n_oe_o      (rst_n_oe_o),
	.halt_o          (halt_o),
	.wr_valid_o      (wr_valid_o),
	.regs_o          (regs_o),
	.wr_o            (wr_o)
);
`default_nettype wire

//--- rsap_pkg.sv
// Shared constants and types for the serial register access port.
package rsap_pkg;
	localparam int          BYTES       = 32;
	localparam logic [5:0]  PTR_RESET   = 6'h00;
	localparam logic [5:0]  CLOCK_END   = 6'h08;
	localparam logic [2:0]  LAST_BIT    = 3'h7;
	localparam logic [7:0]  BYTE_RESET  = 8'h00;
	localparam int          RST_HOLD_MS = 210;
	localparam longint      CLK_HZ      = 40_000_000;
	localparam longint      RST_HOLD_CY = (longint'(RST_HOLD_MS) * CLK_HZ) / 64'd1000;

	typedef enum logic {
		PH_CMD  = 1'b0,
		PH_DATA = 1'b1
	} rsap_phase_t;

	typedef logic [BYTES-1:0][7:0] rsap_map_t;
	typedef logic [7:0][7:0]       rsap_time_t;

	typedef struct packed {
		logic [5:0] addr;
		logic [7:0] data;
	} rsap_wr_t;
endpackage

//--- rsap_spi_master.sv
// Behavioural bus master for the port.
`timescale 1ns/10ps
`default_nettype none
module rsap_spi_master (
	output logic		sclk_o = 1'b0,
	output logic		cs_n_o = 1'b1,
	output logic		serial_in_o = 1'b0,
	input wire logic	serial_out_i
);
	int gap_ns = 0;
	task automatic sel(input logic v);
		#20;
		cs_n_o = v;
		serial_in_o = ~serial_in_o;
		#20;
	endtask
	task automatic xfer(input logic [7:0] t, output logic [7:0] r);
		for (int i = 7; i >= 0; i--) begin
			serial_in_o = t[i];
			#15;
			sclk_o = 1'b1;
			r[i] = serial_out_i;
			#15;
			sclk_o = 1'b0;
		end
		if (gap_ns > 0) begin
			serial_in_o = ~serial_in_o;
			#(gap_ns);
		end
	endtask
endmodule
`default_nettype wire
